// file: src/ccf_exec.v
// Control flow and system instruction executor with internal system stack
`timescale 1ns/1ps
`default_nettype none
`include "ccf_exec_regs.vh"
module ccf_exec (
   input wire clk_in,
   input wire rst_b_in,
   input wire op_valid_in,
   input wire [5:0] op_code_in,
   input wire op_long_in,
   input wire cond_true_in,
   input wire [7:0] byte_in,
   input wire [15:0] word_in,
   input wire [15:0] reg_value_in,
   input wire [7:0] seg_in,
   input wire [7:0] rel_in,
   input wire [6:0] trap_num_in,
   input wire bit_value_in,
   input wire [1:0] seq_count_in,
   input wire [15:0] psw_in,
   input wire irq_in,
   input wire nmi_pin_in,
   input wire addr_short_in,
   input wire [7:0] short_addr_in,
   input wire [13:0] long_offset_in,
   input wire [9:0] dpp_page_in,
   output reg busy_out,
   output reg done_out,
   output reg [15:0] ip_out,
   output reg [7:0] csp_out,
   output reg [3:0] sp_out,
   output reg reg_wr_out,
   output reg [15:0] reg_wr_data_out,
   output reg bit_wr_out,
   output reg bit_wr_value_out,
   output reg psw_load_out,
   output reg [15:0] psw_out,
   output reg sw_reset_out,
   output reg idle_out,
   output reg power_down_out,
   output reg wdt_service_out,
   output reg wdt_disable_out,
   output reg reset_output_pin_b_out,
   output reg atomic_out,
   output reg ext_reg_out,
   output reg ext_page_out,
   output reg ext_seg_out,
   output reg [9:0] ext_value_out,
   output reg [23:0] sfr_addr_out
);
   reg [15:0] stack_mem [0:`CCF_STACK_DEPTH-1];
   reg [2:0] state_q, state_d;
   reg [15:0] ip_q, ip_d;
   reg [7:0] csp_q, csp_d;
   reg [3:0] sp_q, sp_d;
   reg wr_q, wr_d;
   reg [15:0] wdata_q, wdata_d;
   reg bwr_q, bwr_d, bval_q, bval_d;
   reg pswl_q, pswl_d;
   reg [15:0] psw_q, psw_d;
   reg swrst_q, swrst_d, wsrv_q, wsrv_d, wdis_q, wdis_d;
   reg init_pin_b_q, init_pin_b_d;
   reg done_q, done_d;
   reg atomic_q, atomic_d, xreg_q, xreg_d, xpage_q, xpage_d, xseg_q, xseg_d;
   reg [2:0] seq_q, seq_d;
   reg [9:0] extv_q, extv_d;
   reg [23:0] sfr_q;
   reg nmi_s1_q, nmi_s2_q, nmi_s3_q, nmi_lvl_q;
   reg [2:0] push_n, pop_n;
   reg [15:0] push0, push1, push2;
   reg [15:0] ip_next, rel_tgt;
   reg prefix_op;
   wire [3:0] sp_m1 = sp_q - 4'h1;
   wire [3:0] sp_m2 = sp_q - 4'h2;
   wire [3:0] sp_m3 = sp_q - 4'h3;
   wire [3:0] sp_p1 = sp_q + 4'h1;
   wire [3:0] sp_p2 = sp_q + 4'h2;
   wire [15:0] top0 = stack_mem[sp_q];
   wire [15:0] top1 = stack_mem[sp_p1];
   wire [15:0] top2 = stack_mem[sp_p2];
   wire [9:0] page_sel = (xpage_q || xseg_q) ? extv_q : dpp_page_in;
   wire seq_active = atomic_q || xreg_q || xpage_q || xseg_q;

   // Non-maskable pin is asynchronous; accept a level once stages 2 and 3 agree
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         nmi_s1_q <= 1'b1;
         nmi_s2_q <= 1'b1;
         nmi_s3_q <= 1'b1;
         nmi_lvl_q <= 1'b1;
      end else begin
         nmi_s1_q <= nmi_pin_in;
         nmi_s2_q <= nmi_s1_q;
         nmi_s3_q <= nmi_s2_q;
         if (nmi_s2_q == nmi_s3_q) begin
            nmi_lvl_q <= nmi_s3_q;
         end
      end
   end

   always @* begin
      state_d = state_q;
      ip_d = ip_q;
      csp_d = csp_q;
      sp_d = sp_q;
      wr_d = 1'b0;
      wdata_d = wdata_q;
      bwr_d = 1'b0;
      bval_d = bval_q;
      pswl_d = 1'b0;
      psw_d = psw_q;
      swrst_d = 1'b0;
      wsrv_d = 1'b0;
      wdis_d = 1'b0;
      init_pin_b_d = init_pin_b_q;
      done_d = 1'b0;
      atomic_d = atomic_q;
      xreg_d = xreg_q;
      xpage_d = xpage_q;
      xseg_d = xseg_q;
      seq_d = seq_q;
      extv_d = extv_q;
      push_n = 3'h0;
      pop_n = 3'h0;
      push0 = 16'h0000;
      push1 = 16'h0000;
      push2 = 16'h0000;
      prefix_op = 1'b0;
      ip_next = ip_q + (op_long_in ? `CCF_LEN_LONG : `CCF_LEN_SHORT);
      // Relative offset counts words from the following instruction
      rel_tgt = ip_q + `CCF_LEN_LONG + {{7{rel_in[7]}}, rel_in, 1'b0};
      case (state_q)
         `CCF_ST_RUN: begin
            if (op_valid_in) begin
               done_d = 1'b1;
               case (op_code_in)
                  `CCF_OP_BSEXT: begin
                     ip_d = ip_next;
                     wr_d = 1'b1;
                     wdata_d = {{8{byte_in[7]}}, byte_in};
                  end
                  `CCF_OP_BZEXT: begin
                     ip_d = ip_next;
                     wr_d = 1'b1;
                     wdata_d = {8'h00, byte_in};
                  end
                  `CCF_OP_JABS: begin
                     ip_d = cond_true_in ? word_in : ip_q + `CCF_LEN_LONG;
                  end
                  `CCF_OP_JIND: begin
                     ip_d = cond_true_in ? reg_value_in : ip_q + `CCF_LEN_LONG;
                  end
                  `CCF_OP_JREL: begin
                     ip_d = cond_true_in ? rel_tgt : ip_q + `CCF_LEN_LONG;
                  end
                  `CCF_OP_JSEG: begin
                     csp_d = seg_in;
                     ip_d = word_in;
                  end
                  `CCF_OP_JB: begin
                     ip_d = bit_value_in ? rel_tgt : ip_q + `CCF_LEN_LONG;
                  end
                  `CCF_OP_JNB: begin
                     ip_d = !bit_value_in ? rel_tgt : ip_q + `CCF_LEN_LONG;
                  end
                  `CCF_OP_JBCLR: begin
                     ip_d = bit_value_in ? rel_tgt : ip_q + `CCF_LEN_LONG;
                     bwr_d = bit_value_in;
                     bval_d = 1'b0;
                  end
                  `CCF_OP_JNBSET: begin
                     ip_d = !bit_value_in ? rel_tgt : ip_q + `CCF_LEN_LONG;
                     bwr_d = !bit_value_in;
                     bval_d = 1'b1;
                  end
                  `CCF_OP_CABS, `CCF_OP_CIND, `CCF_OP_CREL: begin
                     ip_d = ip_q + `CCF_LEN_LONG;
                     if (cond_true_in) begin
                        push_n = 3'h1;
                        push0 = ip_q + `CCF_LEN_LONG;
                        if (op_code_in == `CCF_OP_CABS) begin
                           ip_d = word_in;
                        end else if (op_code_in == `CCF_OP_CIND) begin
                           ip_d = reg_value_in;
                        end else begin
                           ip_d = rel_tgt;
                        end
                     end
                  end
                  `CCF_OP_CFAR: begin
                     push_n = 3'h2;
                     push0 = {8'h00, csp_q};
                     push1 = ip_q + `CCF_LEN_LONG;
                     csp_d = seg_in;
                     ip_d = word_in;
                  end
                  `CCF_OP_PSHCALL: begin
                     push_n = 3'h2;
                     push0 = reg_value_in;
                     push1 = ip_q + `CCF_LEN_LONG;
                     ip_d = word_in;
                  end
                  `CCF_OP_TRAP: begin
                     push_n = 3'h3;
                     push0 = psw_in;
                     push1 = {8'h00, csp_q};
                     push2 = ip_q + `CCF_LEN_SHORT;
                     csp_d = 8'h00;
                     ip_d = {7'h00, trap_num_in, 2'b00};
                  end
                  `CCF_OP_PUSH: begin
                     ip_d = ip_q + `CCF_LEN_SHORT;
                     push_n = 3'h1;
                     push0 = reg_value_in;
                  end
                  `CCF_OP_POP: begin
                     ip_d = ip_q + `CCF_LEN_SHORT;
                     pop_n = 3'h1;
                     wr_d = 1'b1;
                     wdata_d = top0;
                  end
                  `CCF_OP_SWAP: begin
                     ip_d = ip_q + `CCF_LEN_LONG;
                     push_n = 3'h1;
                     push0 = reg_value_in;
                     wr_d = 1'b1;
                     wdata_d = word_in;
                  end
                  `CCF_OP_RETN: begin
                     pop_n = 3'h1;
                     ip_d = top0;
                  end
                  `CCF_OP_RETF: begin
                     pop_n = 3'h2;
                     ip_d = top0;
                     csp_d = top1[7:0];
                  end
                  `CCF_OP_RETR: begin
                     pop_n = 3'h2;
                     ip_d = top0;
                     wr_d = 1'b1;
                     wdata_d = top1;
                  end
                  `CCF_OP_IRET: begin
                     pop_n = 3'h3;
                     ip_d = top0;
                     csp_d = top1[7:0];
                     pswl_d = 1'b1;
                     psw_d = top2;
                  end
                  `CCF_OP_SWRST: begin
                     ip_d = ip_q + `CCF_LEN_LONG;
                     swrst_d = 1'b1;
                  end
                  `CCF_OP_IDLE: begin
                     ip_d = ip_q + `CCF_LEN_LONG;
                     state_d = `CCF_ST_IDLE;
                  end
                  `CCF_OP_PDOWN: begin
                     ip_d = ip_q + `CCF_LEN_LONG;
                     // With the pin high the stop is refused and acts as a null op
                     if (!nmi_lvl_q) begin
                        state_d = `CCF_ST_PDOWN;
                     end
                  end
                  `CCF_OP_WSRV: begin
                     ip_d = ip_q + `CCF_LEN_LONG;
                     wsrv_d = 1'b1;
                  end
                  `CCF_OP_WDIS: begin
                     ip_d = ip_q + `CCF_LEN_LONG;
                     wdis_d = 1'b1;
                  end
                  `CCF_OP_INITEND: begin
                     ip_d = ip_q + `CCF_LEN_LONG;
                     init_pin_b_d = 1'b1;
                  end
                  `CCF_OP_ATOMIC, `CCF_OP_XREG, `CCF_OP_XPAGE, `CCF_OP_XSEG,
                  `CCF_OP_XPAGER, `CCF_OP_XSEGR: begin
                     prefix_op = 1'b1;
                     ip_d = ip_next;
                     seq_d = {1'b0, seq_count_in} + 3'h1;
                     atomic_d = 1'b1;
                     xreg_d = (op_code_in == `CCF_OP_XREG) ||
                              (op_code_in == `CCF_OP_XPAGER) || (op_code_in == `CCF_OP_XSEGR);
                     xpage_d = (op_code_in == `CCF_OP_XPAGE) || (op_code_in == `CCF_OP_XPAGER);
                     xseg_d = (op_code_in == `CCF_OP_XSEG) || (op_code_in == `CCF_OP_XSEGR);
                     extv_d = op_long_in ? word_in[9:0] : reg_value_in[9:0];
                  end
                  `CCF_OP_NOP: begin
                     ip_d = ip_q + `CCF_LEN_SHORT;
                  end
                  default: begin
                     ip_d = ip_q + `CCF_LEN_SHORT;
                  end
               endcase
               // Sequence ends after seq_count_in plus one following instructions
               if (!prefix_op && seq_active) begin
                  seq_d = seq_q - 3'h1;
                  if (seq_q == 3'h1) begin
                     atomic_d = 1'b0;
                     xreg_d = 1'b0;
                     xpage_d = 1'b0;
                     xseg_d = 1'b0;
                  end
               end
            end
         end
         `CCF_ST_IDLE: begin
            if (irq_in) begin
               state_d = `CCF_ST_RUN;
            end
         end
         `CCF_ST_PDOWN: begin
            // Only a reset leaves power down
            state_d = `CCF_ST_PDOWN;
         end
         default: begin
            state_d = `CCF_ST_RUN;
         end
      endcase
      sp_d = sp_q - {1'b0, push_n} + {1'b0, pop_n};
   end

   // Stack grows downward; overflow wraps silently, software must bound depth
   always @(posedge clk_in) begin
      if (push_n != 3'h0) begin
         stack_mem[sp_m1] <= push0;
      end
      if (push_n[1]) begin
         stack_mem[sp_m2] <= push1;
      end
      if (push_n == 3'h3) begin
         stack_mem[sp_m3] <= push2;
      end
   end

   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q <= `CCF_ST_RUN;
         ip_q <= `CCF_RST_IP;
         csp_q <= `CCF_RST_CSP;
         sp_q <= `CCF_RST_SP;
         wr_q <= 1'b0;
         wdata_q <= 16'h0000;
         bwr_q <= 1'b0;
         bval_q <= 1'b0;
         pswl_q <= 1'b0;
         psw_q <= 16'h0000;
         swrst_q <= 1'b0;
         wsrv_q <= 1'b0;
         wdis_q <= 1'b0;
         init_pin_b_q <= 1'b0;
         done_q <= 1'b0;
         atomic_q <= 1'b0;
         xreg_q <= 1'b0;
         xpage_q <= 1'b0;
         xseg_q <= 1'b0;
         seq_q <= 3'h0;
         extv_q <= 10'h000;
         sfr_q <= 24'h000000;
      end else begin
         state_q <= state_d;
         ip_q <= ip_d;
         csp_q <= csp_d;
         sp_q <= sp_d;
         wr_q <= wr_d;
         wdata_q <= wdata_d;
         bwr_q <= bwr_d;
         bval_q <= bval_d;
         pswl_q <= pswl_d;
         psw_q <= psw_d;
         swrst_q <= swrst_d;
         wsrv_q <= wsrv_d;
         wdis_q <= wdis_d;
         init_pin_b_q <= init_pin_b_d;
         done_q <= done_d;
         atomic_q <= atomic_d;
         xreg_q <= xreg_d;
         xpage_q <= xpage_d;
         xseg_q <= xseg_d;
         seq_q <= seq_d;
         extv_q <= extv_d;
         // Short form skips the page pointers; extended register picks the lower space at 00f000 instead of 00fe00
         if (addr_short_in) begin
            sfr_q <= (xreg_q ? `CCF_ESFR_BASE : `CCF_SFR_BASE) +
                     {15'h0000, short_addr_in, 1'b0};
         end else begin
            sfr_q <= {page_sel, long_offset_in};
         end
      end
   end

   always @* begin
      busy_out = state_q != `CCF_ST_RUN;
      done_out = done_q;
      ip_out = ip_q;
      csp_out = csp_q;
      sp_out = sp_q;
      reg_wr_out = wr_q;
      reg_wr_data_out = wdata_q;
      bit_wr_out = bwr_q;
      bit_wr_value_out = bval_q;
      psw_load_out = pswl_q;
      psw_out = psw_q;
      sw_reset_out = swrst_q;
      idle_out = state_q[1];
      power_down_out = state_q[2];
      wdt_service_out = wsrv_q;
      wdt_disable_out = wdis_q;
      reset_output_pin_b_out = init_pin_b_q;
      atomic_out = atomic_q;
      ext_reg_out = xreg_q;
      ext_page_out = xpage_q;
      ext_seg_out = xseg_q;
      ext_value_out = extv_q;
      sfr_addr_out = sfr_q;
   end
endmodule
`default_nettype wire

// file: src/ccf_exec_regs.vh
// Constants of the control flow executor: op codes, lengths, reset values, bases, stack depth, states
// Behaviour
// - Signed byte move sign-extends into word
// - Unsigned byte move zero-fills upper byte
// - Conditional jumps branch only when condition true
// - Segment jump loads segment and address
// - Bit jumps branch on set or clear
// - Jump on set bit, then clear it
// - Jump on clear bit, then set it
// - Conditional near calls push return, then branch
// - Far call saves segment and return address
// - Push register, then absolute call
// - Trap enters service routine by number
// - Push stores, pop restores a register
// - Context swap pushes register, loads new value
// - Near return keeps code segment
// - Far return restores segment and address
// - Return then pop a register
// - Interrupt return resumes interrupted program
// - Power down needs non-maskable input low
// - Watchdog service, disable, end of init
// - Prefixes start atomic or extended sequences
// - Special registers by long or short address
`ifndef CCF_EXEC_REGS_VH
`define CCF_EXEC_REGS_VH
`define CCF_OP_NOP 6'h00
`define CCF_OP_BSEXT 6'h01
`define CCF_OP_BZEXT 6'h02
`define CCF_OP_JABS 6'h03
`define CCF_OP_JIND 6'h04
`define CCF_OP_JREL 6'h05
`define CCF_OP_JSEG 6'h06
`define CCF_OP_JB 6'h07
`define CCF_OP_JNB 6'h08
`define CCF_OP_JBCLR 6'h09
`define CCF_OP_JNBSET 6'h0a
`define CCF_OP_CABS 6'h0b
`define CCF_OP_CIND 6'h0c
`define CCF_OP_CREL 6'h0d
`define CCF_OP_CFAR 6'h0e
`define CCF_OP_PSHCALL 6'h0f
`define CCF_OP_TRAP 6'h10
`define CCF_OP_PUSH 6'h11
`define CCF_OP_POP 6'h12
`define CCF_OP_SWAP 6'h13
`define CCF_OP_RETN 6'h14
`define CCF_OP_RETF 6'h15
`define CCF_OP_RETR 6'h16
`define CCF_OP_IRET 6'h17
`define CCF_OP_SWRST 6'h18
`define CCF_OP_IDLE 6'h19
`define CCF_OP_PDOWN 6'h1a
`define CCF_OP_WSRV 6'h1b
`define CCF_OP_WDIS 6'h1c
`define CCF_OP_INITEND 6'h1d
`define CCF_OP_ATOMIC 6'h1e
`define CCF_OP_XREG 6'h1f
`define CCF_OP_XPAGE 6'h20
`define CCF_OP_XSEG 6'h21
`define CCF_OP_XPAGER 6'h22
`define CCF_OP_XSEGR 6'h23
`define CCF_LEN_SHORT 16'h0002
`define CCF_LEN_LONG 16'h0004
`define CCF_RST_IP 16'h0000
`define CCF_RST_CSP 8'h00
`define CCF_RST_SP 4'h0
`define CCF_SFR_BASE 24'h00fe00
`define CCF_ESFR_BASE 24'h00f000
`define CCF_STACK_DEPTH 16
`define CCF_ST_RUN 3'h1
`define CCF_ST_IDLE 3'h2
`define CCF_ST_PDOWN 3'h4
`endif

// file: verification/ccf_exec_checker.sv
// Port-level assertions for the control flow executor
`timescale 1ns/1ps
`default_nettype none
`include "ccf_exec_regs.vh"
module ccf_exec_checker (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic op_valid_in,
   input wire logic [5:0] op_code_in,
   input wire logic cond_true_in,
   input wire logic [7:0] byte_in,
   input wire logic [15:0] word_in,
   input wire logic [7:0] seg_in,
   input wire logic bit_value_in,
   input wire logic irq_in,
   input wire logic busy_out,
   input wire logic [15:0] ip_out,
   input wire logic [7:0] csp_out,
   input wire logic [3:0] sp_out,
   input wire logic reg_wr_out,
   input wire logic [15:0] reg_wr_data_out,
   input wire logic bit_wr_out,
   input wire logic bit_wr_value_out,
   input wire logic idle_out,
   input wire logic reset_output_pin_b_out,
   input wire logic atomic_out,
   input wire logic ext_page_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   wire logic take;
   // Requests while busy are dropped, so only these count
   assign take = op_valid_in && !busy_out;
   sequence s_idle_enter;
      take && op_code_in == `CCF_OP_IDLE;
   endsequence
   sequence s_page_start;
      take && op_code_in == `CCF_OP_XPAGE;
   endsequence
   a_signed_byte_ext: assert property (take && op_code_in == `CCF_OP_BSEXT |=>
      reg_wr_out && reg_wr_data_out == {{8{$past(byte_in[7])}}, $past(byte_in)})
      else $error("signed byte move wrong");
   a_unsigned_zero_fill: assert property (take && op_code_in == `CCF_OP_BZEXT |=>
      reg_wr_out && reg_wr_data_out == {8'h00, $past(byte_in)}) else $error("zero fill wrong");
   a_jump_skip_seq: assert property (take && op_code_in == `CCF_OP_JREL
      && !cond_true_in |=> ip_out == $past(ip_out) + 16'h0004)
      else $error("false jump not skipped");
   a_seg_jump_load: assert property (take && op_code_in == `CCF_OP_JSEG |=>
      csp_out == $past(seg_in) && ip_out == $past(word_in)) else $error("segment jump wrong");
   a_set_then_clear: assert property (take && op_code_in == `CCF_OP_JBCLR
      && bit_value_in |=> bit_wr_out && !bit_wr_value_out) else $error("bit not cleared");
   a_clear_then_set: assert property (take && op_code_in == `CCF_OP_JNBSET |=>
      bit_wr_out == !$past(bit_value_in) && (!bit_wr_out || bit_wr_value_out))
      else $error("bit set wrong");
   a_call_push_ret: assert property (take && op_code_in == `CCF_OP_CABS
      && cond_true_in |=> ip_out == $past(word_in) && sp_out == $past(sp_out) - 4'h1)
      else $error("call wrong");
   a_idle_entry: assert property (s_idle_enter |=> idle_out && busy_out)
      else $error("idle not entered");
   a_idle_wake: assert property (idle_out && irq_in |=> !idle_out)
      else $error("idle not left");
   a_init_pin_rise: assert property ($rose(reset_output_pin_b_out) |->
      $past(take) && $past(op_code_in) == `CCF_OP_INITEND) else $error("pin rose without cause");
   a_page_prefix: assert property (s_page_start |=> ext_page_out && atomic_out)
      else $error("page prefix not started");
endmodule
bind ccf_exec ccf_exec_checker u_ccf_exec_checker (.*);
`default_nettype wire

// file: verification/ccf_exec_tb.sv
// Self-checking bench for the control flow executor
`timescale 1ns/1ps
`default_nettype none
`include "ccf_exec_regs.vh"
module ccf_exec_tb;
   logic clk_in = 1'b0, rst_b_in = 1'b0, op_valid_in = 1'b0, op_long_in = 1'b0;
   logic cond_true_in = 1'b0, bit_value_in = 1'b0, irq_in = 1'b0, nmi_pin_in = 1'b1;
   logic addr_short_in = 1'b0;
   logic [5:0] op_code_in = 6'h00;
   logic [7:0] byte_in = 8'h00, seg_in = 8'h00, rel_in = 8'h00, short_addr_in = 8'h00;
   logic [15:0] word_in = 16'h0000, reg_value_in = 16'h0000, psw_in = 16'h0000;
   logic [6:0] trap_num_in = 7'h00;
   logic [1:0] seq_count_in = 2'h0;
   logic [13:0] long_offset_in = 14'h0000;
   logic [9:0] dpp_page_in = 10'h000;
   wire logic busy_out, done_out, reg_wr_out, bit_wr_out, bit_wr_value_out, psw_load_out;
   wire logic sw_reset_out, idle_out, power_down_out, wdt_service_out, wdt_disable_out;
   wire logic reset_output_pin_b_out, atomic_out, ext_reg_out, ext_page_out, ext_seg_out;
   wire logic [15:0] ip_out, reg_wr_data_out, psw_out;
   wire logic [7:0] csp_out;
   wire logic [3:0] sp_out;
   wire logic [9:0] ext_value_out;
   wire logic [23:0] sfr_addr_out;
   int num_errors = 0;
   int comparisons = 0;
   ccf_exec u_ccf_exec (.*);
   always #4 clk_in = ~clk_in;
   task automatic ck(input string n, input logic [23:0] e, input logic [23:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // Leading wait keeps a cycle between requests so valid never toggles twice at once
   task automatic op(input logic [5:0] c);
      @(negedge clk_in);
      op_code_in = c;
      op_valid_in = 1'b1;
      @(negedge clk_in);
      op_valid_in = 1'b0;
   endtask
   task automatic rs();
      rst_b_in = 1'b0;
      repeat (8) @(negedge clk_in);
      rst_b_in = 1'b1;
   endtask
   task automatic finish_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic t_moves();
      rs();
      byte_in = 8'h85;
      op(`CCF_OP_BSEXT);
      ck("sext", 24'hff85, reg_wr_data_out);
      ck("wr", 24'h3, {done_out, reg_wr_out});
      byte_in = 8'h7f;
      op(`CCF_OP_BSEXT);
      ck("sext", 24'h007f, reg_wr_data_out);
      byte_in = 8'h85;
      op(`CCF_OP_BZEXT);
      ck("zext", 24'h0085, reg_wr_data_out);
      $display("moves done");
   endtask
   task automatic t_jumps();
      rs();
      cond_true_in = 1'b1;
      word_in = 16'h1234;
      op(`CCF_OP_JABS);
      ck("ip", 24'h1234, ip_out);
      cond_true_in = 1'b0;
      op(`CCF_OP_JREL);
      ck("ip", 24'h1238, ip_out);
      cond_true_in = 1'b1;
      rel_in = 8'hfe;
      op(`CCF_OP_JREL);
      ck("ip", 24'h1238, ip_out);
      reg_value_in = 16'h2000;
      op(`CCF_OP_JIND);
      ck("ip", 24'h2000, ip_out);
      seg_in = 8'h05;
      word_in = 16'h0100;
      op(`CCF_OP_JSEG);
      ck("csp", 24'h05, csp_out);
      ck("ip", 24'h0100, ip_out);
      $display("jumps done");
   endtask
   task automatic t_bits();
      rs();
      rel_in = 8'h02;
      bit_value_in = 1'b1;
      op(`CCF_OP_JB);
      ck("ip", 24'h0008, ip_out);
      op(`CCF_OP_JNB);
      ck("ip", 24'h000c, ip_out);
      op(`CCF_OP_JBCLR);
      ck("ip", 24'h0014, ip_out);
      ck("bwr", 24'h2, {bit_wr_out, bit_wr_value_out});
      op(`CCF_OP_JNBSET);
      ck("ip", 24'h0018, ip_out);
      ck("bwr", 24'h0, bit_wr_out);
      bit_value_in = 1'b0;
      op(`CCF_OP_JNBSET);
      ck("bwr", 24'h3, {bit_wr_out, bit_wr_value_out});
      op(`CCF_OP_JBCLR);
      ck("ip", 24'h0024, ip_out);
      ck("bwr", 24'h0, bit_wr_out);
      $display("bits done");
   endtask
   task automatic t_far_subroutine_call();
      rs();
      cond_true_in = 1'b0;
      word_in = 16'h3000;
      op(`CCF_OP_CABS);
      ck("sp", 24'h0, sp_out);
      cond_true_in = 1'b1;
      op(`CCF_OP_CABS);
      ck("sp", 24'hf, sp_out);
      op(`CCF_OP_RETN);
      ck("ip", 24'h0008, ip_out);
      seg_in = 8'h07;
      word_in = 16'h4000;
      op(`CCF_OP_CFAR);
      ck("csp", 24'h07, csp_out);
      op(`CCF_OP_RETF);
      ck("seg ip", 24'h00000c, {csp_out, ip_out});
      rel_in = 8'h10;
      op(`CCF_OP_CREL);
      ck("ip", 24'h0030, ip_out);
      reg_value_in = 16'h0500;
      op(`CCF_OP_CIND);
      ck("sp ip", 24'he0500, {sp_out, ip_out});
      $display("far_subroutine_call done");
   endtask
   task automatic t_stack();
      rs();
      reg_value_in = 16'habcd;
      op(`CCF_OP_PUSH);
      ck("sp", 24'hf, sp_out);
      op(`CCF_OP_POP);
      ck("pop", 24'habcd, reg_wr_data_out);
      reg_value_in = 16'h1111;
      word_in = 16'h2222;
      op(`CCF_OP_SWAP);
      ck("swap", 24'h2222, reg_wr_data_out);
      op(`CCF_OP_POP);
      ck("pop", 24'h1111, reg_wr_data_out);
      reg_value_in = 16'h5555;
      word_in = 16'h6000;
      op(`CCF_OP_PSHCALL);
      ck("sp ip", 24'he6000, {sp_out, ip_out});
      op(`CCF_OP_RETR);
      ck("ip", 24'h000e, ip_out);
      ck("reg", 24'h5555, reg_wr_data_out);
      $display("stack done");
   endtask
   task automatic t_trap();
      rs();
      seg_in = 8'h05;
      word_in = 16'h0100;
      op(`CCF_OP_JSEG);
      psw_in = 16'h0f0f;
      trap_num_in = 7'h03;
      op(`CCF_OP_TRAP);
      ck("vec", 24'h00000c, {csp_out, ip_out});
      op(`CCF_OP_IRET);
      ck("back", 24'h050102, {csp_out, ip_out});
      ck("psw", 24'h10f0f, {psw_load_out, psw_out});
      $display("trap done");
   endtask
   task automatic t_system();
      rs();
      ck("pin", 24'h0, reset_output_pin_b_out);
      op(`CCF_OP_SWRST);
      ck("swrst", 24'h10004, {sw_reset_out, ip_out});
      op(`CCF_OP_WSRV);
      ck("wsrv", 24'h1, wdt_service_out);
      op(`CCF_OP_WDIS);
      ck("wdis", 24'h1, wdt_disable_out);
      op(`CCF_OP_INITEND);
      ck("pin", 24'h10010, {reset_output_pin_b_out, ip_out});
      op(`CCF_OP_NOP);
      ck("nop", 24'h0012, {sp_out, ip_out});
      op(`CCF_OP_IDLE);
      ck("idle", 24'h3, {idle_out, busy_out});
      word_in = 16'h7777;
      op(`CCF_OP_JABS);
      ck("ip", 24'h0016, ip_out);
      irq_in = 1'b1;
      @(negedge clk_in);
      irq_in = 1'b0;
      ck("idle", 24'h0, idle_out);
      $display("system done");
   endtask
   task automatic t_pdown();
      rs();
      op(`CCF_OP_PDOWN);
      ck("pdn", 24'h0004, {power_down_out, ip_out});
      nmi_pin_in = 1'b0;
      repeat (4) @(negedge clk_in);
      op(`CCF_OP_PDOWN);
      ck("pdn", 24'h3, {power_down_out, busy_out});
      nmi_pin_in = 1'b1;
      $display("power down done");
   endtask
   task automatic t_prefix();
      rs();
      op_long_in = 1'b1;
      seq_count_in = 2'h1;
      word_in = 16'h0155;
      op(`CCF_OP_XPAGE);
      ck("page", 24'hd55, {ext_page_out, atomic_out, ext_value_out});
      op_long_in = 1'b0;
      op(`CCF_OP_NOP);
      ck("page", 24'h1, ext_page_out);
      op(`CCF_OP_NOP);
      ck("page", 24'h0, {ext_page_out, atomic_out});
      seq_count_in = 2'h0;
      op(`CCF_OP_ATOMIC);
      ck("atom", 24'h1, atomic_out);
      op(`CCF_OP_XREG);
      ck("xreg", 24'h1, ext_reg_out);
      reg_value_in = 16'h0033;
      op(`CCF_OP_XSEGR);
      ck("xseg", 24'hc33, {ext_seg_out, ext_reg_out, ext_value_out});
      $display("prefix done");
   endtask
   task automatic t_sfr();
      rs();
      addr_short_in = 1'b1;
      short_addr_in = 8'h25;
      repeat (2) @(negedge clk_in);
      ck("short", 24'h00fe4a, sfr_addr_out);
      addr_short_in = 1'b0;
      dpp_page_in = 10'h003;
      long_offset_in = 14'h0abc;
      repeat (2) @(negedge clk_in);
      ck("long", 24'h00cabc, sfr_addr_out);
      $display("sfr done");
   endtask
   initial begin
      repeat (5000) @(posedge clk_in);
      num_errors++;
      finish_test();
   end
   initial begin
      t_moves();
      t_jumps();
      t_bits();
      t_far_subroutine_call();
      t_stack();
      t_trap();
      t_system();
      t_pdown();
      t_prefix();
      t_sfr();
      finish_test();
   end
endmodule
`default_nettype wire
